// File: include/adcseq_pkg.sv
`default_nettype none
package adcseq_pkg;
  // special-function addresses
  localparam logic [7:0] ADCSEQ_CTRL_ADDR   = 8'hA0;
  localparam logic [7:0] ADCSEQ_RESULT_ADDR = 8'h84;
  // control register fields
  localparam int ADCSEQ_ENABLE_POS = 5;
  localparam int ADCSEQ_DONE_POS   = 4;
  localparam int ADCSEQ_START_POS  = 3;
  localparam int ADCSEQ_CHAN_LSB   = 0;
  localparam int ADCSEQ_CHAN_W     = 3;
  localparam int ADCSEQ_IRQ_EN_POS = 6;
  // reset values
  localparam logic [7:0] ADCSEQ_CTRL_RESET   = 8'hC0;
  localparam logic [7:0] ADCSEQ_RESULT_RESET = 8'h00;
  localparam logic [7:0] ADCSEQ_UNUSED_BITS  = 8'hC0;
  // timing and geometry
  localparam int         ADCSEQ_CONV_CYCLES = 40;
  localparam logic [5:0] ADCSEQ_CNT_LAST    = 6'(ADCSEQ_CONV_CYCLES - 1);
  localparam int         ADCSEQ_CHANNELS    = 5;
  localparam int         ADCSEQ_DATA_W      = 8;
endpackage : adcseq_pkg
`default_nettype wire

// File: include/adcseq_conv_if.sv
`timescale 1ns/1ps
`default_nettype none
interface adcseq_conv_if;
  logic       start;
  logic [2:0] channel;
  logic       done;
  logic [7:0] result;
  modport ctrl (output start, output channel, input done, input result);
  modport core (input start, input channel, output done, output result);
endinterface : adcseq_conv_if
`default_nettype wire

// File: rtl/adcseq_mux.sv
`timescale 1ns/1ps
`default_nettype none
module adcseq_mux
  import adcseq_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // conversion link
  adcseq_conv_if.core      conv,
  // digitised channel samples
  input  wire logic [39:0] chan_data,
  // abort from power modes or a cleared enable
  input  wire logic        abort
);
  logic [7:0] sel_ff, nxt_sel;
  logic [7:0] word [ADCSEQ_CHANNELS];

  genvar g;
  generate
    for (g = 0; g < ADCSEQ_CHANNELS; g++) begin : g_ch
      assign word[g] = chan_data[g*8 +: 8];
    end
  endgenerate

  // codes above 4 pick no pin; result reads zero
  always_comb begin
    nxt_sel = sel_ff;
    if (conv.start) begin
      nxt_sel = (conv.channel < 3'(ADCSEQ_CHANNELS)) ? word[conv.channel] : 8'h00;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_ff <= 8'h00;
    end else begin
      sel_ff <= nxt_sel;
    end
  end

  // sample held at start, taken by the top on finish; done tied low
  assign conv.result = sel_ff;
  assign conv.done   = 1'b0;
  logic unused_abort;
  assign unused_abort = abort;
endmodule : adcseq_mux
`default_nettype wire

// File: rtl/adcseq_top.sv
`timescale 1ns/1ps
`default_nettype none
module adcseq_top
  import adcseq_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // special-function bus, byte wide
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  output logic      [7:0]  sfr_rdata,
  // interrupt enable register bit from the cpu
  input  wire logic        converter_irq_enable,
  // power modes from the cpu
  input  wire logic        idle_mode,
  input  wire logic        power_down,
  // converted channel samples
  input  wire logic [39:0] chan_data,
  // outputs
  output logic             irq_req,
  output logic [4:0]       analog_pin_sel,
  output logic             converter_enabled
);
  typedef enum logic [0:0] {
    ADCSEQ_IDLE = 1'b0,
    ADCSEQ_BUSY = 1'b1
  } adcseq_state_t;

  // sequencer state
  adcseq_state_t state_ff,  nxt_state;
  logic [5:0]    cnt_ff,    nxt_cnt;
  // control register fields
  logic          enable_ff, nxt_enable;
  logic [2:0]    chan_ff,   nxt_chan;
  // completion flag and result byte
  logic          done_ff,   nxt_done;
  logic [7:0]    result_ff, nxt_result;
  // output registers
  logic [7:0]    rdata_ff,  nxt_rdata;
  logic          irq_ff,    nxt_irq;
  logic [4:0]    pin_ff,    nxt_pin;
  // decoded bus and sequencer events
  logic          start_bit;
  logic          wr_ctrl;
  logic          rd_result;
  logic          accept;
  logic          power_save;
  logic          abort;
  logic          finish;

  adcseq_conv_if conv ();

  adcseq_mux u_mux (
    .clk       (clk),
    .reset_n   (reset_n),
    .conv      (conv),
    .chan_data (chan_data),
    .abort     (abort)
  );

  assign start_bit  = (state_ff == ADCSEQ_BUSY);
  assign wr_ctrl    = sfr_wr && (sfr_addr == ADCSEQ_CTRL_ADDR);
  assign rd_result  = sfr_rd && (sfr_addr == ADCSEQ_RESULT_ADDR);
  assign power_save = idle_mode || power_down;
  // start only from idle and enabled; anything else is dropped
  assign accept     = wr_ctrl && sfr_wdata[ADCSEQ_START_POS] && enable_ff && !start_bit && !done_ff
                      && !power_save;
  // power modes or a cleared enable cut a running conversion short
  assign abort      = start_bit && (power_save || !enable_ff);
  assign finish     = start_bit && !abort && (cnt_ff == ADCSEQ_CNT_LAST);

  assign conv.start   = accept;
  assign conv.channel = chan_ff;

  // control fields; channel frozen while busy or while done is set
  always_comb begin
    nxt_enable = enable_ff;
    nxt_chan   = chan_ff;
    if (wr_ctrl) begin
      nxt_enable = sfr_wdata[ADCSEQ_ENABLE_POS];
      if (!done_ff && !start_bit) begin
        nxt_chan = sfr_wdata[ADCSEQ_CHAN_LSB +: ADCSEQ_CHAN_W];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_ff <= ADCSEQ_CTRL_RESET[ADCSEQ_ENABLE_POS];
      chan_ff   <= ADCSEQ_CTRL_RESET[ADCSEQ_CHAN_LSB +: ADCSEQ_CHAN_W];
    end else begin
      enable_ff <= nxt_enable;
      chan_ff   <= nxt_chan;
    end
  end

  // sequencer counts edges from the accepting one
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      ADCSEQ_IDLE: begin
        if (accept) begin
          nxt_state = ADCSEQ_BUSY;
          nxt_cnt   = 6'h00;
        end
      end
      ADCSEQ_BUSY: begin
        if (abort || finish) begin
          nxt_state = ADCSEQ_IDLE;
        end else begin
          nxt_cnt = cnt_ff + 6'h01;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ADCSEQ_IDLE;
      cnt_ff   <= 6'h00;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // set wins over a read clear in the same cycle
  always_comb begin
    nxt_done   = done_ff;
    nxt_result = result_ff;
    if (rd_result) begin
      nxt_done = 1'b0;
    end
    if (finish) begin
      nxt_done   = 1'b1;
      nxt_result = conv.result;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_ff   <= ADCSEQ_CTRL_RESET[ADCSEQ_DONE_POS];
      result_ff <= ADCSEQ_RESULT_RESET;
    end else begin
      done_ff   <= nxt_done;
      result_ff <= nxt_result;
    end
  end

  // read-back shows each register as it stands after this edge
  always_comb begin
    nxt_rdata = 8'h00;
    if (sfr_addr == ADCSEQ_CTRL_ADDR) begin
      nxt_rdata = ADCSEQ_UNUSED_BITS;
      nxt_rdata[ADCSEQ_ENABLE_POS] = nxt_enable;
      nxt_rdata[ADCSEQ_DONE_POS]   = nxt_done;
      nxt_rdata[ADCSEQ_START_POS]  = (nxt_state == ADCSEQ_BUSY);
      nxt_rdata[ADCSEQ_CHAN_LSB +: ADCSEQ_CHAN_W] = nxt_chan;
    end else if (sfr_addr == ADCSEQ_RESULT_ADDR) begin
      nxt_rdata = nxt_result;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // request and pin select track the flags of this edge
  always_comb begin
    nxt_irq = nxt_done && converter_irq_enable;
    nxt_pin = 5'h00;
    if (nxt_enable && (nxt_chan < 3'(ADCSEQ_CHANNELS))) begin
      nxt_pin = 5'(5'h01 << nxt_chan);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_ff <= 1'b0;
      pin_ff <= 5'h00;
    end else begin
      irq_ff <= nxt_irq;
      pin_ff <= nxt_pin;
    end
  end

  assign sfr_rdata         = rdata_ff;
  assign irq_req           = irq_ff;
  assign analog_pin_sel    = pin_ff;
  assign converter_enabled = enable_ff;
  logic unused_done;
  assign unused_done = conv.done;
endmodule : adcseq_top
`default_nettype wire

// File: tb/adcseq_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module adcseq_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // bus
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_rdata,
  // cpu side
  input wire logic        converter_irq_enable,
  input wire logic        idle_mode,
  input wire logic        power_down,
  input wire logic [39:0] chan_data,
  // outputs
  input wire logic        irq_req,
  input wire logic [4:0]  analog_pin_sel,
  input wire logic        converter_enabled
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  en_follow_a: assert property (
    sfr_wr && sfr_addr == 8'hA0 && sfr_wdata[5] |-> ##[1:2] converter_enabled) else $error("enable lost");
  pin_onehot_a: assert property ($onehot0(analog_pin_sel)) else $error("pin select not one-hot");
  pin_off_a: assert property (
    !converter_enabled && !$past(converter_enabled) |-> analog_pin_sel == 5'h00) else $error("pin while off");
  fixed_bits_a: assert property (
    sfr_rd && sfr_addr == 8'hA0 |=> sfr_rdata[7:6] == 2'b11) else $error("top bits not one");
  unmapped_a: assert property (
    sfr_rd && sfr_addr != 8'hA0 && sfr_addr != 8'h84 |=> sfr_rdata == 8'h00) else $error("unmapped not zero");
  state_excl_a: assert property (
    sfr_rd && sfr_addr == 8'hA0 |=> !(sfr_rdata[4] && sfr_rdata[3])) else $error("done and start both set");
  irq_gate_a: assert property (irq_req |-> $past(converter_irq_enable)) else $error("irq while masked");
  read_clear_a: assert property (
    sfr_rd && sfr_addr == 8'hA0 ##1 sfr_rd && sfr_addr == 8'h84 && sfr_rdata[4] ##1 sfr_rd && sfr_addr == 8'hA0
    |=> !sfr_rdata[4]) else $error("done not cleared by read");
endmodule // adcseq_chk
bind adcseq_top adcseq_chk i_chk (.*);
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 0, reset_n = 0, sfr_wr = 0, sfr_rd = 0, idle_mode = 0;
  logic        converter_irq_enable = 1, power_down = 0, irq_req, converter_enabled;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [39:0] chan_data = 40'h5EA43C961B;
  logic [4:0]  analog_pin_sel;
  int          fail_count = 0, n_tests = 0;
  always #50 clk = ~clk;
  adcseq_top i_dut (.*);
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // one bus cycle, called at a falling edge
  task automatic acc(logic [7:0] a, logic [7:0] d, logic w, logic r);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = w;
    sfr_rd = r;
    @(negedge clk);
  endtask
  task automatic t_reset();
    acc(8'hA0, 8'h08, 1, 0);
    acc(8'hA0, 8'h00, 0, 1);
    chk("ctrl", sfr_rdata, 8'hC0);
    chk("enabled", {7'h0, converter_enabled}, 8'h00);
    acc(8'h84, 8'h00, 0, 1);
    chk("result", sfr_rdata, 8'h00);
    acc(8'h90, 8'h00, 0, 1);
    chk("unmapped", sfr_rdata, 8'h00);
  endtask
  task automatic t_conv(logic [2:0] c);
    logic [7:0] x;
    x = (c < 5) ? chan_data[8*c +: 8] : 8'h00;
    acc(8'hA0, 8'h20 | c, 1, 0);
    acc(8'hA0, 8'h28 | c, 1, 0);
    acc(8'hA0, {5'h07, ~c}, 1, 0);
    chk("pin", {3'h0, analog_pin_sel}, (c < 5) ? 8'h01 << c : 8'h00);
    chk("enabled", {7'h0, converter_enabled}, 8'h01);
    for (int i = 2; i <= 40; i++) begin
      acc(8'hA0, 8'h00, 0, 1);
      chk("ctrl", sfr_rdata, (i < 40 ? 8'hE8 : 8'hF0) | c);
    end
    acc(8'h00, 8'h00, 0, 0);
    chk("irq", {7'h0, irq_req}, 8'h01);
    converter_irq_enable = 0;
    acc(8'h00, 8'h00, 0, 0);
    chk("irq masked", {7'h0, irq_req}, 8'h00);
    converter_irq_enable = 1;
    acc(8'hA0, {5'h07, ~c}, 1, 0);
    acc(8'hA0, 8'h00, 0, 1);
    chk("pending", sfr_rdata, 8'hF0 | c);
    acc(8'h84, 8'h00, 0, 1);
    chk("result", sfr_rdata, x);
    acc(8'hA0, 8'h00, 0, 1);
    chk("cleared", sfr_rdata, 8'hE0 | c);
    chk("irq", {7'h0, irq_req}, 8'h00);
  endtask
  task automatic t_abort();
    acc(8'hA0, 8'h20, 1, 0);
    acc(8'hA0, 8'h28, 1, 0);
    idle_mode = 1;
    acc(8'h00, 8'h00, 0, 0);
    idle_mode = 0;
    repeat (45) acc(8'hA0, 8'h00, 0, 1);
    chk("abort", sfr_rdata, 8'hE0);
    acc(8'hA0, 8'h28, 1, 0);
    power_down = 1;
    acc(8'h00, 8'h00, 0, 0);
    power_down = 0;
    repeat (45) acc(8'hA0, 8'h00, 0, 1);
    chk("pd abort", sfr_rdata, 8'hE0);
    acc(8'hA0, 8'h28, 1, 0);
    repeat (41) acc(8'hA0, 8'h00, 0, 1);
    idle_mode = 1;
    repeat (3) acc(8'hA0, 8'h00, 0, 1);
    idle_mode = 0;
    chk("idle keeps", sfr_rdata, 8'hF0);
    acc(8'h84, 8'h00, 0, 1);
    chk("idle result", sfr_rdata, chan_data[7:0]);
    acc(8'hA0, 8'h00, 0, 1);
    chk("idle clear", sfr_rdata, 8'hE0);
    acc(8'hA0, 8'h28, 1, 0);
    acc(8'hA0, 8'h00, 1, 0);
    repeat (45) acc(8'hA0, 8'h00, 0, 1);
    chk("off abort", sfr_rdata, 8'hC0);
    chk("off enabled", {7'h0, converter_enabled}, 8'h00);
    chk("off pin", {3'h0, analog_pin_sel}, 8'h00);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1;
    t_reset();
    for (int c = 0; c < 6; c++) t_conv(3'(c));
    t_abort();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
